// [pkg/partial_display_pkg.sv]
// Constants, types and helpers shared by the partial-display line selector
package partial_display_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_FIRST_AREA  = 4'h0;
  localparam logic [3:0] OFS_SECOND_AREA = 4'h4;
  localparam logic [3:0] OFS_CONTROL     = 4'h8;
  localparam logic [3:0] OFS_STATUS      = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int START_LSB     = 0;
  localparam int END_LSB       = 8;
  localparam int ENABLE2_BIT   = 0;
  localparam int BLANK_SEL_LSB = 1;
  localparam int COUNT_LSB     = 8;
  localparam int ST_LINE_LSB   = 0;
  localparam int ST_GATE_BIT   = 8;
  localparam int ST_BAD_BIT    = 9;
  localparam int ST_BADSEL_BIT = 10;
  localparam int ST_MODE_LSB   = 11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FIRST_START_RST  = 8'h00;
  localparam logic [7:0] FIRST_END_RST    = 8'hEF;
  localparam logic [7:0] SECOND_START_RST = 8'h00;
  localparam logic [7:0] SECOND_END_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST        = 8'hEF;
  localparam logic [1:0] BLANK_SEL_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FULL    = 2'b00,
    MODE_PARTIAL = 2'b01,
    MODE_BAD     = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    SRC_DATA   = 3'b000,
    SRC_TOP    = 3'b001,
    SRC_BOTTOM = 3'b010,
    SRC_GND    = 3'b011,
    SRC_HIZ    = 3'b100
  } src_t;

  localparam logic [1:0] SEL_GRAY    = 2'b00;
  localparam logic [1:0] SEL_ILLEGAL = 2'b01;
  localparam logic [1:0] SEL_GND     = 2'b10;
  localparam logic [1:0] SEL_HIZ     = 2'b11;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_area(input logic [7:0] line, input logic [7:0] s, input logic [7:0] e);
    in_area = (line >= s) && (line <= e);
  endfunction : in_area

  function automatic logic [8:0] span_len(input logic [7:0] s, input logic [7:0] e);
    span_len = {1'b0, e} - {1'b0, s};
  endfunction : span_len

  // Illegal code 01 falls back to ground, the least stressful level
  function automatic src_t blank_src(input logic [1:0] sel, input logic positive);
    case (sel)
      SEL_GRAY: blank_src = positive ? SRC_TOP : SRC_BOTTOM;
      SEL_GND:  blank_src = SRC_GND;
      SEL_HIZ:  blank_src = SRC_HIZ;
      default: blank_src = SRC_GND;
    endcase
  endfunction : blank_src

endpackage : partial_display_pkg

// [pkg/line_class_if.sv]
// Carrier between the line scanner and the line classifier
`timescale 1ns/1ps
interface line_class_if;
  import partial_display_pkg::*;
  logic [7:0] line;
  logic [7:0] first_area_start_line;
  logic [7:0] first_area_end_line;
  logic [7:0] second_area_start_line;
  logic [7:0] second_area_end_line;
  logic [7:0] driven_line_count;
  logic       second_area_enable;
  logic       displayed;
  mode_t      mode;

  modport requester (
    output line, first_area_start_line, first_area_end_line, second_area_start_line,
    output second_area_end_line, driven_line_count, second_area_enable,
    input  displayed, mode
  );
  modport classifier (
    input  line, first_area_start_line, first_area_end_line, second_area_start_line,
    input  second_area_end_line, driven_line_count, second_area_enable,
    output displayed, mode
  );
endinterface : line_class_if

// [logic/line_classifier.sv]
// Decides whether one gate line lies in a displayed area
`timescale 1ns/1ps
module line_classifier (
  line_class_if.classifier cls
);
  import partial_display_pkg::*;

  logic [8:0] total;
  logic       in_first;
  logic       in_second;
  logic       in_whole;

  always_comb begin
    in_first  = in_area(cls.line, cls.first_area_start_line, cls.first_area_end_line);
    in_second = in_area(cls.line, cls.second_area_start_line, cls.second_area_end_line);
    in_whole  = in_area(cls.line, cls.first_area_start_line, cls.second_area_end_line);
    total     = span_len(cls.first_area_start_line, cls.first_area_end_line);
    if (cls.second_area_enable) begin
      total = total + span_len(cls.second_area_start_line, cls.second_area_end_line);
    end
    if (total > {1'b0, cls.driven_line_count}) begin
      cls.mode = MODE_BAD;
    end else if (total == {1'b0, cls.driven_line_count}) begin
      cls.mode = MODE_FULL;
    end else begin
      cls.mode = MODE_PARTIAL;
    end
    // A setting the panel cannot honour blanks every line rather than guess
    case (cls.mode)
      MODE_FULL:    cls.displayed = cls.second_area_enable ? in_whole : in_first;
      MODE_PARTIAL: cls.displayed = in_first || (cls.second_area_enable && in_second);
      default:      cls.displayed = 1'b0;
    endcase
  end

endmodule : line_classifier

// [logic/partial_display_line_select.sv]
// Partial-display line selector with AHB-Lite configuration registers
//
// Summary of operation
// - With second area disabled, its bounds are ignored; only first area shows.
// - Two areas whose lengths sum to line count: show first start to second end.
// - Two areas summing below line count: show areas, blank level elsewhere.
// - Two-bit select picks blank source level: gray refs, ground or high impedance.
// - Only gate lines inside displayed areas are driven.
// - First area from first start/end fields, second from second fields.
// - Second area counts only while its enable bit is one.
`timescale 1ns/1ps
module partial_display_line_select #(
  parameter int LINES = 240
) (
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic [31:0]                           hrdata,
  input  wire logic                             line_tick,
  input  wire logic                             positive_polarity,
  output logic                                  gate_on,
  output partial_display_pkg::src_t             source_level,
  output logic [7:0]                            line_index
);
  import partial_display_pkg::*;

  localparam logic [7:0] LAST_LINE = 8'(LINES - 1);

  typedef struct packed {
    logic [7:0]  s1;
    logic [7:0]  e1;
    logic [7:0]  s2;
    logic [7:0]  e2;
    logic [7:0]  count;
    logic        en2;
    logic [1:0]  bsel;
    logic        wr_pend;
    logic [3:0]  wr_addr;
    logic [31:0] rdata;
    logic        readyout;
    logic [7:0]  line;
    logic        pol_s1;
    logic        pol_s2;
    logic        tick_s1;
    logic        tick_s2;
    logic        tick_s3;
    logic        gate;
    src_t        src;
    logic [7:0]  out_line;
  } state_t;

  state_t st;
  state_t next_st;

  line_class_if cls ();

  line_classifier u_classifier (
    .cls (cls)
  );

  assign cls.line                   = st.line;
  assign cls.first_area_start_line  = st.s1;
  assign cls.first_area_end_line    = st.e1;
  assign cls.second_area_start_line = st.s2;
  assign cls.second_area_end_line   = st.e2;
  assign cls.driven_line_count      = st.count;
  assign cls.second_area_enable     = st.en2;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_read(input state_t s, input logic [3:0] a, input mode_t m);
    reg_read = 32'h0000_0000;
    case (a)
      OFS_FIRST_AREA: begin
        reg_read[START_LSB +: 8] = s.s1;
        reg_read[END_LSB +: 8]   = s.e1;
      end
      OFS_SECOND_AREA: begin
        reg_read[START_LSB +: 8] = s.s2;
        reg_read[END_LSB +: 8]   = s.e2;
      end
      OFS_CONTROL: begin
        reg_read[ENABLE2_BIT]       = s.en2;
        reg_read[BLANK_SEL_LSB +: 2] = s.bsel;
        reg_read[COUNT_LSB +: 8]    = s.count;
      end
      OFS_STATUS: begin
        reg_read[ST_LINE_LSB +: 8] = s.out_line;
        reg_read[ST_GATE_BIT]      = s.gate;
        reg_read[ST_BAD_BIT]       = (m == MODE_BAD);
        reg_read[ST_BADSEL_BIT]    = (s.bsel == SEL_ILLEGAL);
        reg_read[ST_MODE_LSB +: 2] = m;
      end
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.readyout = 1'b1;
    // Zero-wait slave: a write lands at the end of its data phase
    if (st.wr_pend) begin
      case (st.wr_addr)
        OFS_FIRST_AREA: begin
          next_st.s1 = hwdata[START_LSB +: 8];
          next_st.e1 = hwdata[END_LSB +: 8];
        end
        OFS_SECOND_AREA: begin
          next_st.s2 = hwdata[START_LSB +: 8];
          next_st.e2 = hwdata[END_LSB +: 8];
        end
        OFS_CONTROL: begin
          next_st.en2   = hwdata[ENABLE2_BIT];
          next_st.bsel  = hwdata[BLANK_SEL_LSB +: 2];
          next_st.count = hwdata[COUNT_LSB +: 8];
        end
        default: next_st.count = st.count;
      endcase
    end
    next_st.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = {haddr[3:2], 2'b00};
      next_st.rdata   = hwrite ? 32'h0000_0000 : reg_read(st, {haddr[3:2], 2'b00}, cls.mode);
    end
    // Pins from the panel timing side pass two flops before use
    next_st.pol_s1  = positive_polarity;
    next_st.pol_s2  = st.pol_s1;
    next_st.tick_s1 = line_tick;
    next_st.tick_s2 = st.tick_s1;
    next_st.tick_s3 = st.tick_s2;
    if (st.tick_s2 && !st.tick_s3) begin
      next_st.line = (st.line >= LAST_LINE) ? 8'h00 : st.line + 8'h01;
    end
    next_st.gate     = cls.displayed;
    next_st.src      = cls.displayed ? SRC_DATA : blank_src(st.bsel, st.pol_s2);
    next_st.out_line = st.line;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= '0;
      st.s1       <= FIRST_START_RST;
      st.e1       <= FIRST_END_RST;
      st.s2       <= SECOND_START_RST;
      st.e2       <= SECOND_END_RST;
      st.count    <= COUNT_RST;
      st.bsel     <= BLANK_SEL_RST;
      st.src      <= SRC_BOTTOM;
      st.readyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout    = st.readyout;
  assign hresp        = 1'b0;
  assign hrdata       = st.rdata;
  assign gate_on      = st.gate;
  assign source_level = st.src;
  assign line_index   = st.out_line;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [8:0] chk_sum;
  logic       chk_in1;
  logic       chk_in2;
  logic       chk_span;
  assign chk_sum  = span_len(st.s1, st.e1) + (st.en2 ? span_len(st.s2, st.e2) : 9'h000);
  assign chk_in1  = in_area(st.line, st.s1, st.e1);
  assign chk_in2  = in_area(st.line, st.s2, st.e2);
  assign chk_span = in_area(st.line, st.s1, st.en2 ? st.e2 : st.e1);

  property p_single_only;
    !st.en2 && !chk_in1 |=> !gate_on;
  endproperty
  a_single_only: assert property (p_single_only) else $error("line outside first area driven");

  property p_two_full;
    st.en2 && (chk_sum == {1'b0, st.count}) && in_area(st.line, st.s1, st.e2) |=> gate_on && source_level == SRC_DATA;
  endproperty
  a_two_full: assert property (p_two_full) else $error("full two-area span not displayed");

  property p_two_partial;
    st.en2 && (chk_sum < {1'b0, st.count}) && !chk_in1 && !chk_in2 |=> !gate_on && source_level != SRC_DATA;
  endproperty
  a_two_partial: assert property (p_two_partial) else $error("gap line shows ram data");

  property p_blank_level;
    !gate_on |-> source_level == blank_src($past(st.bsel), $past(st.pol_s2));
  endproperty
  a_blank_level: assert property (p_blank_level) else $error("wrong blank source level");

  property p_gate_only_areas;
    gate_on |-> $past(chk_span) && source_level == SRC_DATA;
  endproperty
  a_gate_only_areas: assert property (p_gate_only_areas) else $error("gate driven outside areas");

  property p_second_area;
    st.en2 && (chk_sum <= {1'b0, st.count}) && chk_in2 |=> gate_on;
  endproperty
  a_second_area: assert property (p_second_area) else $error("second area line not driven");

  property p_enable_gate;
    $fell(st.en2) && !chk_in1 && chk_in2 |=> !gate_on;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("second area kept after disable");

  property p_inclusive_end;
    (st.line == st.e1 || st.line == st.s1) && (chk_sum <= {1'b0, st.count}) |=> gate_on;
  endproperty
  a_inclusive_end: assert property (p_inclusive_end) else $error("boundary line not driven");

  property p_line_step;
    st.tick_s2 && !st.tick_s3 |=> st.line == (($past(st.line) >= LAST_LINE) ? 8'h00 : $past(st.line) + 8'h01);
  endproperty
  a_line_step: assert property (p_line_step) else $error("line counter step wrong");

  c_partial_gap: cover property (st.en2 && chk_sum < {1'b0, st.count} && !chk_in1 && !chk_in2 ##1 !gate_on);
  c_full_two:    cover property (st.en2 && chk_sum == {1'b0, st.count} ##1 gate_on);
  c_illegal_sel: cover property (st.bsel == SEL_ILLEGAL ##1 !gate_on);

endmodule : partial_display_line_select

// [tb/panel_model.sv]
// Panel-side model that paces the gate line scan
`timescale 1ns/1ps
module panel_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      line_tick
);
  // ----------------------------------------------------------------
  // Line pacing
  // ----------------------------------------------------------------
  // Four clocks high and four low keep each level past the two-flop sync
  logic [2:0] phase;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase     <= 3'h0;
      line_tick <= 1'b0;
    end else begin
      phase     <= phase + 3'h1;
      line_tick <= phase[2];
    end
  end
endmodule : panel_model

// [tb/tb.sv]
// Self-checking bench for the partial-display line selector
`timescale 1ns/1ps
module tb;
  import partial_display_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        line_tick;
  logic        positive_polarity;
  logic        gate_on;
  src_t        source_level;
  logic [7:0]  line_index;
  int          fails;
  int          samples_checked;
  int          cycles;

  partial_display_line_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_tick(line_tick),
    .positive_polarity(positive_polarity), .gate_on(gate_on), .source_level(source_level),
    .line_index(line_index));
  panel_model panel (.hclk(hclk), .hresetn(hresetn), .line_tick(line_tick));

  always #50 hclk = ~hclk;

  // Whole run is about 12k cycles; the ceiling leaves room to spare
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk_word

  task automatic chk_line(input int l, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value line %0d gate/source expected %h seen %h", l, e, g);
    end
  endtask : chk_line

  task automatic ahb(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb

  // ----------------------------------------------------------------
  // Frame scan against the expected line pattern
  // ----------------------------------------------------------------
  function automatic logic [3:0] want(input int l, s1, e1, s2, e2, input bit en, input int cnt,
                                      input logic [1:0] sel, input bit pol);
    int          sum;
    bit          shown;
    logic [2:0]  blank;
    sum = (e1 - s1) + (en ? (e2 - s2) : 0);
    if (sum > cnt) shown = 0;
    else if (!en) shown = (l >= s1) && (l <= e1);
    else if (sum == cnt) shown = (l >= s1) && (l <= e2);
    else shown = ((l >= s1) && (l <= e1)) || ((l >= s2) && (l <= e2));
    case (sel)
      2'b00:   blank = pol ? 3'h1 : 3'h2;
      2'b11:   blank = 3'h4;
      default: blank = 3'h3;
    endcase
    want = shown ? 4'h8 : {1'b0, blank};
  endfunction : want

  task automatic scan(input logic [7:0] s1, e1, s2, e2, input logic en, input logic [7:0] cnt,
                      input logic [1:0] sel, input logic pol);
    logic [31:0] q;
    logic [7:0]  last;
    int          n;
    ahb(OFS_FIRST_AREA, 1'b1, {16'h0000, e1, s1}, q);
    ahb(OFS_SECOND_AREA, 1'b1, {16'h0000, e2, s2}, q);
    ahb(OFS_CONTROL, 1'b1, {16'h0000, cnt, 5'h00, sel, en}, q);
    positive_polarity <= pol;
    repeat (16) @(posedge hclk);
    @(negedge hclk);
    last = line_index;
    n = 0;
    while (n < 240) begin
      @(negedge hclk);
      if (line_index !== last) begin
        chk_word("line index step", {24'h0, (last == 8'hEF) ? 8'h00 : last + 8'h01}, {24'h0, line_index});
        last = line_index;
        n++;
        chk_line(line_index, want(line_index, s1, e1, s2, e2, en, cnt, sel, pol), {gate_on, source_level});
      end
    end
    $display("test scan %h-%h %h-%h en %b done", s1, e1, s2, e2, en);
  endtask : scan

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    ahb(OFS_FIRST_AREA, 1'b0, 32'h0, q);
    chk_word("first area reset", 32'h0000EF00, q);
    ahb(OFS_SECOND_AREA, 1'b0, 32'h0, q);
    chk_word("second area reset", 32'h00000000, q);
    ahb(OFS_CONTROL, 1'b0, 32'h0, q);
    chk_word("control reset", 32'h0000EF00, q);
    ahb(OFS_SECOND_AREA, 1'b1, 32'h00003322, q);
    ahb(OFS_SECOND_AREA, 1'b0, 32'h0, q);
    chk_word("second area readback", 32'h00003322, q);
    chk_word("bus response", 32'h00000000, {31'h0, hresp});
    $display("test registers done");
  endtask : t_regs

  task automatic t_disabled();
    logic [31:0] q;
    ahb(OFS_STATUS, 1'b0, 32'h0, q);
    chk_word("status partial flags", 32'h00000C00, q & 32'h00001E00);
    scan(8'h00, 8'h80, 8'h90, 8'hEF, 1'b1, 8'h40, 2'b00, 1'b1);
    ahb(OFS_STATUS, 1'b0, 32'h0, q);
    chk_word("status disabled flags", 32'h00001200, q & 32'h00001A00);
    $display("test status flags done");
  endtask : t_disabled

  task automatic close_out();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Host ordering of bounds is kept by every scan call with the second area enabled
  initial begin
    hclk              = 1'b0;
    hresetn           = 1'b0;
    hsel              = 1'b0;
    haddr             = 32'h0;
    htrans            = 2'h0;
    hwrite            = 1'b0;
    hwdata            = 32'h0;
    positive_polarity = 1'b1;
    fails             = 0;
    samples_checked   = 0;
    cycles            = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    scan(8'h10, 8'h20, 8'h40, 8'h50, 1'b0, 8'hEF, 2'b00, 1'b1);
    scan(8'h00, 8'h05, 8'h10, 8'hEF, 1'b1, 8'hEF, 2'b10, 1'b0);
    scan(8'h05, 8'h0A, 8'h0B, 8'h14, 1'b1, 8'h0E, 2'b00, 1'b0);
    scan(8'h20, 8'h2F, 8'h00, 8'hEF, 1'b0, 8'hEF, 2'b11, 1'b0);
    scan(8'h20, 8'h2F, 8'h00, 8'h00, 1'b0, 8'hEF, 2'b01, 1'b1);
    t_disabled();
    close_out();
  end
endmodule : tb
